/* File: pcg_pkg.sv */
package pcg_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int PORT_N = 5;
  localparam int PORT_SEL_W = 3;

  localparam logic [ADDR_W-1:0] RUN_PORT_CLOCK_ENABLE_OFF = 12'h108;
  localparam logic [ADDR_W-1:0] SLEEP_PORT_CLOCK_ENABLE_OFF = 12'h118;
  localparam logic [ADDR_W-1:0] DEEP_SLEEP_PORT_CLOCK_ENABLE_OFF = 12'h128;
  localparam logic [ADDR_W-1:0] RUN_CLOCK_CONFIGURATION_OFF = 12'h060;
  localparam logic [ADDR_W-1:0] ACTIVE_PORT_CLOCK_OFF = 12'h140;
  localparam logic [ADDR_W-1:0] PORT_FAULT_STATUS_OFF = 12'h144;

  localparam int PORT_A_BIT = 0;
  localparam int PORT_B_BIT = 1;
  localparam int PORT_C_BIT = 2;
  localparam int PORT_D_BIT = 3;
  localparam int PORT_E_BIT = 4;
  localparam int AUTO_SLEEP_GATING_BIT = 0;

  localparam logic [PORT_N-1:0] PORT_ENABLE_RESET = 5'h00;
  localparam logic AUTO_SLEEP_GATING_RESET = 1'b0;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    PCG_PWR_RUN = 2'b00,
    PCG_PWR_SLEEP = 2'b01,
    PCG_PWR_DEEP = 2'b10
  } pcg_pwr_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pcg_bus_req_s;

  typedef struct packed {
    logic valid;
    logic [PORT_SEL_W-1:0] sel;
  } pcg_port_acc_s;

endpackage : pcg_pkg

/* File: pcg_port_clock_gating.sv */
// Behaviour
// - a port whose enable bit is one in the register chosen for the power state gets its clock.
// - a port whose enable bit is zero in the chosen register has its clock stopped.
// - any access aimed at a port whose clock is off is answered with a bus fault.
// - after reset every enable bit of the sleep and deep-sleep registers is zero.
// - in sleep with automatic gating on, the enables come from the sleep register at 0x118.
// - in deep sleep with automatic gating on, the enables come from the deep-sleep register at 0x128.
// - while running, the enables come from the run register whatever the other two hold.
// - the sleep and deep-sleep registers apply only while the automatic gating bit is set.
// - each gating register holds port A at bit 0 through port E at bit 4.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module pcg_port_clock_gating (
  input wire logic clk,
  input wire logic rst_n,
  input wire pcg_pkg::pcg_bus_req_s bus_req,
  output logic [pcg_pkg::DATA_W-1:0] rdata,
  input wire pcg_pkg::pcg_pwr_e pwr_state,
  input wire pcg_pkg::pcg_port_acc_s port_acc,
  output logic port_fault,
  output logic [pcg_pkg::PORT_N-1:0] port_clk_on,
  output logic [pcg_pkg::PORT_N-1:0] port_gclk
);

  typedef enum logic [2:0] {
    PCG_REG_NONE = 3'b000,
    PCG_REG_RUN = 3'b001,
    PCG_REG_SLEEP = 3'b010,
    PCG_REG_DEEP = 3'b011,
    PCG_REG_CFG = 3'b100,
    PCG_REG_ACTIVE = 3'b101,
    PCG_REG_FAULT = 3'b110
  } pcg_reg_e;

  // one decoder feeds both the write and the read path so the two
  // can never disagree about which register an address names
  function automatic pcg_reg_e reg_decode(
    input logic [pcg_pkg::ADDR_W-1:0] addr
  );
    reg_decode = PCG_REG_NONE;
    unique case (addr)
      pcg_pkg::RUN_PORT_CLOCK_ENABLE_OFF: begin
        reg_decode = PCG_REG_RUN;
      end
      pcg_pkg::SLEEP_PORT_CLOCK_ENABLE_OFF: begin
        reg_decode = PCG_REG_SLEEP;
      end
      pcg_pkg::DEEP_SLEEP_PORT_CLOCK_ENABLE_OFF: begin
        reg_decode = PCG_REG_DEEP;
      end
      pcg_pkg::RUN_CLOCK_CONFIGURATION_OFF: begin
        reg_decode = PCG_REG_CFG;
      end
      pcg_pkg::ACTIVE_PORT_CLOCK_OFF: begin
        reg_decode = PCG_REG_ACTIVE;
      end
      pcg_pkg::PORT_FAULT_STATUS_OFF: begin
        reg_decode = PCG_REG_FAULT;
      end
      default: begin
        reg_decode = PCG_REG_NONE;
      end
    endcase
  endfunction : reg_decode

  // only the port bits of a write word are kept; the rest vanish
  function automatic logic [pcg_pkg::PORT_N-1:0] enable_field(
    input logic [pcg_pkg::DATA_W-1:0] word
  );
    enable_field = word[pcg_pkg::PORT_N-1:0];
  endfunction : enable_field

  // software-visible enables and the automatic gating bit
  logic [pcg_pkg::PORT_N-1:0] run_port_clock_enable_r;
  logic [pcg_pkg::PORT_N-1:0] sleep_port_clock_enable_r;
  logic [pcg_pkg::PORT_N-1:0] deep_sleep_port_clock_enable_r;
  logic auto_sleep_gating_r;

  // effective enables and the per-port gate latches
  logic [pcg_pkg::PORT_N-1:0] port_clk_on_r;
  logic [pcg_pkg::PORT_N-1:0] port_clk_on_nxt;
  logic [pcg_pkg::PORT_N-1:0] gate_en_lat;

  // fault bookkeeping
  logic [pcg_pkg::PORT_N-1:0] fault_status_r;
  logic [pcg_pkg::PORT_N-1:0] fault_set;
  logic [pcg_pkg::PORT_N-1:0] fault_clr;

  // read path
  logic [pcg_pkg::DATA_W-1:0] rdata_r;
  logic [pcg_pkg::DATA_W-1:0] rdata_nxt;
  pcg_reg_e req_sel;

  logic wr_run;
  logic wr_sleep;
  logic wr_deep;
  logic wr_cfg;
  logic wr_fault;

  assign req_sel = reg_decode(bus_req.addr);

  // read-only and unmapped addresses fall to the default and write nothing
  always_comb begin
    wr_run = 1'b0;
    wr_sleep = 1'b0;
    wr_deep = 1'b0;
    wr_cfg = 1'b0;
    wr_fault = 1'b0;
    if (bus_req.wr) begin
      unique case (req_sel)
        PCG_REG_RUN: begin
          wr_run = 1'b1;
        end
        PCG_REG_SLEEP: begin
          wr_sleep = 1'b1;
        end
        PCG_REG_DEEP: begin
          wr_deep = 1'b1;
        end
        PCG_REG_CFG: begin
          wr_cfg = 1'b1;
        end
        PCG_REG_FAULT: begin
          wr_fault = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // only bits 4:0 are stored, the upper write data is dropped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_port_clock_enable_r <= pcg_pkg::PORT_ENABLE_RESET;
    end else if (wr_run) begin
      run_port_clock_enable_r <= enable_field(bus_req.wdata);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sleep_port_clock_enable_r <= pcg_pkg::PORT_ENABLE_RESET;
    end else if (wr_sleep) begin
      sleep_port_clock_enable_r <= enable_field(bus_req.wdata);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      deep_sleep_port_clock_enable_r <= pcg_pkg::PORT_ENABLE_RESET;
    end else if (wr_deep) begin
      deep_sleep_port_clock_enable_r <= enable_field(bus_req.wdata);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      auto_sleep_gating_r <= pcg_pkg::AUTO_SLEEP_GATING_RESET;
    end else if (wr_cfg) begin
      auto_sleep_gating_r <= bus_req.wdata[pcg_pkg::AUTO_SLEEP_GATING_BIT];
    end
  end

  // the unused power-state code falls back to the run register so a
  // glitched state never leaves every port unclocked by accident
  function automatic logic [pcg_pkg::PORT_N-1:0] pick_enables(
    input pcg_pkg::pcg_pwr_e state,
    input logic auto_on,
    input logic [pcg_pkg::PORT_N-1:0] run_en,
    input logic [pcg_pkg::PORT_N-1:0] sleep_en,
    input logic [pcg_pkg::PORT_N-1:0] deep_en
  );
    pick_enables = run_en;
    if (auto_on) begin
      unique case (state)
        pcg_pkg::PCG_PWR_RUN: begin
          pick_enables = run_en;
        end
        pcg_pkg::PCG_PWR_SLEEP: begin
          pick_enables = sleep_en;
        end
        pcg_pkg::PCG_PWR_DEEP: begin
          pick_enables = deep_en;
        end
        default: begin
          pick_enables = run_en;
        end
      endcase
    end
  endfunction : pick_enables

  // a change of state or of the auto bit shows one edge later
  always_comb begin
    port_clk_on_nxt = pick_enables(
      pwr_state,
      auto_sleep_gating_r,
      run_port_clock_enable_r,
      sleep_port_clock_enable_r,
      deep_sleep_port_clock_enable_r
    );
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_clk_on_r <= pcg_pkg::PORT_ENABLE_RESET;
    end else begin
      port_clk_on_r <= port_clk_on_nxt;
    end
  end

  assign port_clk_on = port_clk_on_r;

  // enable is latched while clk is low so the gated clock never glitches;
  // a flop here would let the enable change while clk is high and chop
  // a pulse short
  genvar gi;
  generate
    for (gi = 0; gi < pcg_pkg::PORT_N; gi++) begin : g_gate
      always_latch begin
        if (!clk) begin
          gate_en_lat[gi] <= port_clk_on_r[gi];
        end
      end
      assign port_gclk[gi] = clk & gate_en_lat[gi];
    end
  endgenerate

  // a select beyond port E has no unit behind it and faults as well,
  // but there is no status bit to record it in
  function automatic logic sel_is_gated(
    input logic [pcg_pkg::PORT_SEL_W-1:0] sel,
    input logic [pcg_pkg::PORT_N-1:0] clk_on
  );
    sel_is_gated = 1'b1;
    if (sel < 3'(pcg_pkg::PORT_N)) begin
      sel_is_gated = !clk_on[sel];
    end
  endfunction : sel_is_gated

  assign port_fault = port_acc.valid
    && sel_is_gated(port_acc.sel, port_clk_on_r);

  for (gi = 0; gi < pcg_pkg::PORT_N; gi++) begin : g_fault_set
    assign fault_set[gi] = port_acc.valid
      && (port_acc.sel == 3'(gi))
      && !port_clk_on_r[gi];
  end

  assign fault_clr = wr_fault ? enable_field(bus_req.wdata) : '0;

  // write one to clear; a fault in the clearing cycle still lands
  for (gi = 0; gi < pcg_pkg::PORT_N; gi++) begin : g_fault_status
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        fault_status_r[gi] <= pcg_pkg::PORT_ENABLE_RESET[gi];
      end else if (fault_set[gi]) begin
        fault_status_r[gi] <= 1'b1;
      end else if (fault_clr[gi]) begin
        fault_status_r[gi] <= 1'b0;
      end
    end
  end

  always_comb begin
    rdata_nxt = pcg_pkg::READ_ZERO;
    if (bus_req.rd) begin
      unique case (req_sel)
        PCG_REG_RUN: begin
          rdata_nxt[pcg_pkg::PORT_N-1:0] = run_port_clock_enable_r;
        end
        PCG_REG_SLEEP: begin
          rdata_nxt[pcg_pkg::PORT_N-1:0] = sleep_port_clock_enable_r;
        end
        PCG_REG_DEEP: begin
          rdata_nxt[pcg_pkg::PORT_N-1:0] = deep_sleep_port_clock_enable_r;
        end
        PCG_REG_CFG: begin
          rdata_nxt[pcg_pkg::AUTO_SLEEP_GATING_BIT] = auto_sleep_gating_r;
        end
        PCG_REG_ACTIVE: begin
          rdata_nxt[pcg_pkg::PORT_N-1:0] = port_clk_on_r;
        end
        PCG_REG_FAULT: begin
          rdata_nxt[pcg_pkg::PORT_N-1:0] = fault_status_r;
        end
        default: begin
          rdata_nxt = pcg_pkg::READ_ZERO;
        end
      endcase
    end
  end

  // zero outside the answer cycle so stale data never looks valid
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_r <= pcg_pkg::READ_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;

endmodule : pcg_port_clock_gating

`default_nettype wire

/* File: pcg_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module pcg_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire pcg_pkg::pcg_bus_req_s bus_req,
  input wire logic [31:0] rdata,
  input wire pcg_pkg::pcg_pwr_e pwr_state,
  input wire pcg_pkg::pcg_port_acc_s port_acc,
  input wire logic port_fault,
  input wire logic [4:0] port_clk_on
);
  // shadow of the enables, rebuilt from bus writes, so no internal probing is needed
  logic [4:0] run_r, slp_r, dp_r;
  logic auto_r;
  wire [11:0] wa = bus_req.wr ? bus_req.addr : 12'hFFF;
  wire [4:0] wd = bus_req.wdata[4:0];
  wire s_on = auto_r && pwr_state == 2'h1;
  wire d_on = auto_r && pwr_state == 2'h2;
  always_ff @(posedge clk) begin
    if (!rst_n) {auto_r, dp_r, slp_r, run_r} <= 16'h0000;
    else begin
      if (wa == 12'h108) run_r <= wd;
      if (wa == 12'h118) slp_r <= wd;
      if (wa == 12'h128) dp_r <= wd;
      if (wa == 12'h060) auto_r <= wd[0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_fault_off: assert property (port_acc.valid && port_acc.sel < 3'h5 |->
    port_fault == !port_clk_on[port_acc.sel]) else $error("fault wrong");
  a_run_pick: assert property (!$past(s_on || d_on) |->
    port_clk_on == $past(run_r)) else $error("run set wrong");
  a_auto_off: assert property ($past(!auto_r) |->
    port_clk_on == $past(run_r)) else $error("auto off wrong");
  a_sleep_pick: assert property ($past(s_on) |->
    port_clk_on == $past(slp_r)) else $error("sleep set wrong");
  a_deep_pick: assert property ($past(d_on) |->
    port_clk_on == $past(dp_r)) else $error("deep set wrong");
  a_reset_clear: assert property ($rose(rst_n) |->
    port_clk_on == 5'h00 && rdata == 32'h0) else $error("reset wrong");
  a_read_slp: assert property (bus_req.rd && bus_req.addr == 12'h118 |=>
    rdata == {27'h0, $past(slp_r)}) else $error("sleep read wrong");
  a_read_dp: assert property (bus_req.rd && bus_req.addr == 12'h128 |=>
    rdata == {27'h0, $past(dp_r)}) else $error("deep read wrong");
  cover property (s_on ##2 port_clk_on != 5'h00);
  cover property (d_on);
  cover property (port_acc.valid && port_fault);
endmodule : pcg_monitor
bind pcg_port_clock_gating pcg_monitor u_mon (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
  .rdata(rdata), .pwr_state(pwr_state), .port_acc(port_acc), .port_fault(port_fault),
  .port_clk_on(port_clk_on));
`default_nettype wire

/* File: pcg_port_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pcg_port_model (
  input wire logic [4:0] port_gclk,
  input wire logic clr,
  output logic [7:0] edges [5]
);
  // a unit only advances on edges of its own gated clock
  for (genvar i = 0; i < 5; i++) begin : g_unit
    always @(posedge port_gclk[i] or posedge clr) begin
      if (clr) edges[i] <= 8'h00;
      else edges[i] <= edges[i] + 8'h01;
    end
  end
endmodule : pcg_port_model
`default_nettype wire

/* File: tb_port_clock_gating_sleep.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_port_clock_gating_sleep;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clr = 1'b0;
  pcg_pkg::pcg_bus_req_s bus_req = '0;
  pcg_pkg::pcg_pwr_e pwr_state = pcg_pkg::PCG_PWR_RUN;
  pcg_pkg::pcg_port_acc_s port_acc = '0;
  logic [31:0] rdata;
  logic port_fault;
  logic [4:0] port_clk_on, port_gclk;
  logic [7:0] edges [5];
  logic [22:0] r;
  int errors = 0;
  int cmp_count = 0;
  // power, auto, run, sleep, deep, expected clocks; code 3 must act as run
  logic [22:0] rows [6] = '{{2'h0, 1'h1, 5'h03, 5'h0C, 5'h11, 5'h03},
    {2'h1, 1'h1, 5'h03, 5'h1F, 5'h11, 5'h1F}, {2'h2, 1'h1, 5'h03, 5'h0C, 5'h00, 5'h00},
    {2'h1, 1'h0, 5'h03, 5'h0C, 5'h11, 5'h03}, {2'h2, 1'h0, 5'h1F, 5'h0C, 5'h11, 5'h1F},
    {2'h3, 1'h1, 5'h0A, 5'h0C, 5'h11, 5'h0A}};
  pcg_port_clock_gating u_dut (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
    .pwr_state(pwr_state), .port_acc(port_acc), .port_fault(port_fault),
    .port_clk_on(port_clk_on), .port_gclk(port_gclk));
  pcg_port_model u_ports (.port_gclk(port_gclk), .clr(clr), .edges(edges));
  initial forever #20 clk = ~clk;
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("BAD %0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus_req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clk);
    bus_req <= '0;
    @(negedge clk);
    check(rdata, e);
    @(posedge clk);
  endtask : rd
  task automatic reset_check(input int n);
    rst_n <= 1'b0;
    repeat (n) @(posedge clk);
    rst_n <= 1'b1;
    rd(12'h118, 32'h0);
    rd(12'h128, 32'h0);
    @(negedge clk);
    check(32'(port_clk_on), 32'h0);
    @(posedge clk);
  endtask : reset_check
  task automatic tally_and_finish;
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    reset_check(6);
    foreach (rows[i]) begin
      r = rows[i];
      wr(12'h144, 32'h1F);
      wr(12'h060, {31'h0, r[20]});
      // upper bits set on purpose, they must be dropped
      wr(12'h108, {27'h7FFFFFF, r[19:15]});
      wr(12'h118, {27'h7FFFFFF, r[14:10]});
      wr(12'h128, {27'h7FFFFFF, r[9:5]});
      bus_req <= '0;
      pwr_state <= pcg_pkg::pcg_pwr_e'(r[22:21]);
      @(posedge clk);
      @(negedge clk);
      check(32'(port_clk_on), 32'(r[4:0]));
      clr = 1'b1;
      #1 clr = 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      for (int p = 0; p < 5; p++) check(32'(edges[p]), r[p] ? 32'h4 : 32'h0);
      for (int p = 0; p < 6; p++) begin
        @(posedge clk);
        port_acc <= '{1'b1, 3'(p)};
        @(negedge clk);
        check(32'(port_fault), p > 4 ? 32'h1 : 32'(!r[p]));
      end
      @(posedge clk);
      port_acc <= '0;
      rd(12'h118, 32'(r[14:10]));
      rd(12'h128, 32'(r[9:5]));
      rd(12'h108, 32'(r[19:15]));
      rd(12'h060, 32'(r[20]));
      rd(12'h140, 32'(r[4:0]));
      rd(12'h144, {27'h0, ~r[4:0]});
    end
    rd(12'h200, 32'h0);
    reset_check(3);
    port_acc <= '{1'b1, 3'h0};
    @(negedge clk);
    check(32'(port_fault), 32'h1);
    @(posedge clk);
    wr(12'h108, 32'h1);
    bus_req <= '0;
    @(posedge clk);
    @(negedge clk);
    check(32'(port_fault), 32'h0);
    tally_and_finish;
  end
endmodule : tb_port_clock_gating_sleep
`default_nettype wire
